// File: rtl/rtc_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the RTC status block
// Assumes: 40 MHz system clock
// Notes: Definitions only
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
`define CS_OFFSET 8'h0f
`define SLAVE_ADDR 7'h68
`define CS_RESET 8'ha0
`define OSF_BIT 7
`define STOP_DETECT_DISABLE_BIT 6
`define LOS_BIT 5
`define EXT_BIT 2
`define A2F_BIT 1
`define A1F_BIT 0
`define CLK_HZ 40000000
`define REF_HZ_1 1
`define REF_HZ_50 50
`define REF_HZ_60 60
`define REF_HZ_32K 32768
`define REF_TOL_PERMILLE 8
`define TIMEOUT_US 25000
`define TIMEOUT_CYC (`TIMEOUT_US * (`CLK_HZ / 1000000))
`define WAVE_TAP_1HZ 14
`define WAVE_TAP_8K 1
`define WAVE_TAP_4K 2
`endif

// File: rtl/rtc_pkg.sv
// Purpose: Types shared by the RTC status block
// Assumes: Nothing
// Notes: Constants live in rtc_regs.svh
package rtc_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_RD = 3'b101,
    ST_RD_ACK = 3'b110,
    ST_IGNORE = 3'b111
  } i2c_state_e;
endpackage

// File: rtl/rtc_status_port.sv
// Purpose: Control/status register, alarm steering, square wave and serial slave port of the RTC
// Assumes: Pins and crystal signals are asynchronous; control bits and alarm matches are on clock
// Notes: Pins are open drain, oe high pulls low; other registers reached by reg_addr/reg_wr/reg_rdata
`timescale 1ns/100ps
`include "rtc_regs.svh"
module rtc_status_port #(
  parameter int TIMEOUT_CYC = `TIMEOUT_CYC,
  parameter int REF_PER_1 = `CLK_HZ / `REF_HZ_1,
  parameter int REF_PER_50 = `CLK_HZ / `REF_HZ_50,
  parameter int REF_PER_60 = `CLK_HZ / `REF_HZ_60,
  parameter int REF_PER_32K = `CLK_HZ / `REF_HZ_32K
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic ref_in_or_irq_pin_a_in,
  output logic ref_in_or_irq_pin_a_out,
  output logic ref_in_or_irq_pin_a_oe,
  output logic wave_or_irq_pin_b_out,
  output logic wave_or_irq_pin_b_oe,
  input wire logic osc_clk_pin,
  input wire logic osc_running_pin,
  input wire logic osc_disable_bit,
  input wire logic wave_rate_sel_hi,
  input wire logic wave_rate_sel_lo,
  input wire logic irq_steer_select,
  input wire logic alarm_one_irq_en,
  input wire logic alarm_two_irq_en,
  input wire logic alarm_one_match,
  input wire logic alarm_two_match,
  output rtc_pkg::byte_t reg_addr,
  output rtc_pkg::byte_t reg_wdata,
  output logic reg_wr,
  input wire rtc_pkg::byte_t reg_rdata
);
  import rtc_pkg::*;

  localparam int CW = 26;

  // Two-stage synchronisers for scl, sda, pin A, crystal clock, run status
  logic [4:0] meta_q, sync_q, prev_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= 5'h1f; // Idle pin levels, so no false edge after reset
      sync_q <= 5'h1f;
      prev_q <= 5'h1f;
    end else begin
      meta_q <= {osc_running_pin, osc_clk_pin, ref_in_or_irq_pin_a_in, sda_in, scl_pin};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, ref_rise, osc_tick, osc_live;
  always_comb begin
    scl_s = sync_q[0];
    sda_s = sync_q[1];
    scl_rise = scl_s && !prev_q[0];
    scl_fall = !scl_s && prev_q[0];
    start_det = scl_s && prev_q[0] && !sda_s && prev_q[1];
    stop_det = scl_s && prev_q[0] && sda_s && !prev_q[1];
    ref_rise = sync_q[2] && !prev_q[2];
    osc_live = sync_q[4] && !osc_disable_bit;
    osc_tick = sync_q[3] && !prev_q[3] && osc_live;
  end

  // Serial slave state
  i2c_state_e st_q, st_d;
  logic [3:0] bit_q, bit_d;
  byte_t sh_q, sh_d, ptr_q, ptr_d, addr_q, addr_d, wdat_q, wdat_d;
  logic rw_q, rw_d, first_q, first_d, drv_q, drv_d, wr_q, wr_d;
  logic [CW-1:0] tmo_q, tmo_d;
  byte_t status, rd_byte;

  always_comb begin
    rd_byte = (addr_q == `CS_OFFSET) ? status : reg_rdata;
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    wdat_d = wdat_q;
    rw_d = rw_q;
    first_d = first_q;
    drv_d = drv_q;
    wr_d = 1'b0;
    tmo_d = (!scl_s && osc_live && st_q != ST_IDLE) ? tmo_q + 1'b1 : '0;
    if (tmo_q == CW'(TIMEOUT_CYC - 1)) begin
      st_d = ST_IDLE;
      drv_d = 1'b0;
      tmo_d = '0;
    end else if (start_det) begin
      st_d = ST_ADDR;
      bit_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop_det) begin
      st_d = ST_IDLE;
      drv_d = 1'b0;
    end else begin
      case (st_q)
        ST_ADDR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            if (sh_q[7:1] == `SLAVE_ADDR) begin
              drv_d = 1'b1;
              rw_d = sh_q[0];
              st_d = ST_ADDR_ACK;
            end else begin
              st_d = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              sh_d = rd_byte;
              drv_d = !rd_byte[7];
              st_d = ST_RD;
            end else begin
              drv_d = 1'b0;
              first_d = 1'b1;
              st_d = ST_WR;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            drv_d = 1'b1;
            st_d = ST_WR_ACK;
            if (first_q) begin
              ptr_d = sh_q;
              first_d = 1'b0;
            end else begin
              wr_d = 1'b1;
              wdat_d = sh_q;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            drv_d = 1'b0;
            bit_d = 4'h0;
            st_d = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            drv_d = 1'b0;
            ptr_d = ptr_q + 8'h01;
            st_d = ST_RD_ACK;
          end else if (scl_fall && bit_q != 4'h0) begin
            sh_d = {sh_q[6:0], 1'b0};
            drv_d = !sh_q[6];
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_d = ST_IGNORE;
            end else begin
              bit_d = 4'h9;
            end
          end else if (scl_fall && bit_q == 4'h9) begin
            sh_d = rd_byte;
            drv_d = !rd_byte[7];
            bit_d = 4'h0;
            st_d = ST_RD;
          end
        end
        default: begin
          drv_d = 1'b0;
        end
      endcase
    end
    addr_d = wr_d ? ptr_q : ptr_d;
  end

  // Slave port registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      addr_q <= 8'h00;
      wdat_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      drv_q <= 1'b0;
      wr_q <= 1'b0;
      tmo_q <= '0;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rw_q <= rw_d;
      first_q <= first_d;
      drv_q <= drv_d;
      wr_q <= wr_d;
      tmo_q <= tmo_d;
    end
  end

  // Reference period measurement and status register next values
  logic osf_q, osf_d, stop_detect_disable_q, stop_detect_disable_d, los_q, los_d, ext_q, ext_d, a1_q, a1_d, a2_q, a2_d;
  logic inh_q, inh_d, bad_q, bad_d, live_q, cs_wr, ref_stop, ref_dev;
  logic [1:0] fsel_q, fsel_d;
  logic [CW-1:0] rcnt_q, rcnt_d, exp_per, tol;

  always_comb begin
    case (fsel_q)
      2'b00: exp_per = CW'(REF_PER_1);
      2'b01: exp_per = CW'(REF_PER_50);
      2'b10: exp_per = CW'(REF_PER_60);
      default: exp_per = CW'(REF_PER_32K);
    endcase
    tol = CW'((32'(exp_per) * `REF_TOL_PERMILLE) / 1000);
    ref_stop = rcnt_q > exp_per + tol;
    ref_dev = ref_rise && (rcnt_q < exp_per - tol || ref_stop);
    rcnt_d = (!ext_q || ref_rise) ? '0 : (ref_stop ? rcnt_q : rcnt_q + 1'b1);
    bad_d = ref_rise ? ref_dev : (bad_q || ref_stop);
    cs_wr = wr_q && addr_q == `CS_OFFSET;
    osf_d = osf_q;
    stop_detect_disable_d = stop_detect_disable_q;
    los_d = los_q;
    ext_d = ext_q;
    fsel_d = fsel_q;
    a1_d = a1_q;
    a2_d = a2_q;
    inh_d = inh_q && ext_q;
    if (cs_wr) begin
      stop_detect_disable_d = wdat_q[`STOP_DETECT_DISABLE_BIT];
      ext_d = wdat_q[`EXT_BIT];
      fsel_d = wdat_q[4:3];
      osf_d = osf_q && wdat_q[`OSF_BIT];
      los_d = los_q && wdat_q[`LOS_BIT];
      a1_d = a1_q && wdat_q[`A1F_BIT];
      a2_d = a2_q && wdat_q[`A2F_BIT];
      if (!wdat_q[`LOS_BIT] && bad_q) begin
        inh_d = 1'b1;
      end
    end
    if (live_q && !osc_live) begin
      osf_d = 1'b1;
    end
    if (stop_detect_disable_q) begin
      osf_d = 1'b0;
    end
    if (!ext_q || ref_stop || (ref_dev && !inh_q)) begin
      los_d = 1'b1;
    end
    if (alarm_one_match) begin
      a1_d = 1'b1;
    end
    if (alarm_two_match) begin
      a2_d = 1'b1;
    end
    status = {osf_q, stop_detect_disable_q, los_q, fsel_q, ext_q, a2_q, a1_q};
  end

  // Status register; reset value has stopped and missing flags set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {osf_q, stop_detect_disable_q, los_q, fsel_q, ext_q, a2_q, a1_q} <= `CS_RESET;
      inh_q <= 1'b0;
      bad_q <= 1'b0;
      live_q <= 1'b0;
      rcnt_q <= '0;
    end else begin
      {osf_q, stop_detect_disable_q, los_q, fsel_q, ext_q, a2_q, a1_q} <= {osf_d, stop_detect_disable_d, los_d, fsel_d, ext_d, a2_d, a1_d};
      inh_q <= inh_d;
      bad_q <= bad_d;
      live_q <= osc_live;
      rcnt_q <= rcnt_d;
    end
  end

  // Square wave divider and pin steering
  logic [14:0] wcnt_q, wcnt_d;
  logic wave, irq_a, irq_b, a_oe_q, b_oe_q, a1_on, a2_on;
  always_comb begin
    wcnt_d = osc_tick ? wcnt_q + 15'h0001 : wcnt_q;
    case ({wave_rate_sel_hi, wave_rate_sel_lo})
      2'b00: wave = wcnt_q[`WAVE_TAP_1HZ];
      2'b01: wave = wcnt_q[`WAVE_TAP_4K];
      2'b10: wave = wcnt_q[`WAVE_TAP_8K];
      default: wave = sync_q[3];
    endcase
    a1_on = a1_q && alarm_one_irq_en;
    a2_on = a2_q && alarm_two_irq_en;
    irq_a = !ext_q && (a1_on || (!irq_steer_select && a2_on));
    irq_b = irq_steer_select ? (a2_on || (ext_q && a1_on)) : !wave;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wcnt_q <= 15'h0000;
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
    end else begin
      wcnt_q <= wcnt_d;
      a_oe_q <= irq_a;
      b_oe_q <= irq_b;
    end
  end

  // Open-drain drivers and register side port
  assign sda_out = 1'b0;
  assign sda_oe = drv_q;
  assign ref_in_or_irq_pin_a_out = 1'b0;
  assign ref_in_or_irq_pin_a_oe = a_oe_q;
  assign wave_or_irq_pin_b_out = 1'b0;
  assign wave_or_irq_pin_b_oe = b_oe_q;
  assign reg_addr = addr_q;
  assign reg_wdata = wdat_q;
  assign reg_wr = wr_q;
endmodule

// File: verif/rtc_status_port_checker.sv
// Purpose: Port-level assertions for the RTC status and serial port block
// Assumes: Sees only the block's ports
// Notes: Bound into every instance of the block
`timescale 1ns/100ps
module rtc_status_port_checker #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_pin,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic ref_in_or_irq_pin_a_out,
  input wire logic wave_or_irq_pin_b_out,
  input wire logic wave_or_irq_pin_b_oe,
  input wire logic osc_clk_pin,
  input wire logic osc_running_pin,
  input wire logic osc_disable_bit,
  input wire logic wave_rate_sel_hi,
  input wire logic wave_rate_sel_lo,
  input wire logic irq_steer_select,
  input wire logic alarm_two_irq_en,
  input wire logic alarm_two_match,
  input wire logic reg_wr,
  input wire rtc_pkg::byte_t reg_addr
);
  import rtc_pkg::*;
  int low_q, low_d;
  byte_t wa_q, wa_d;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // SCL low time and last write address
  always_comb begin
    low_d = !(!scl_pin && osc_running_pin && !osc_disable_bit) ? 0 : (low_q > TIMEOUT_CYC + 50) ? low_q : low_q + 1;
    wa_d = reg_wr ? reg_addr : wa_q;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_q <= 0;
      wa_q <= 8'h00;
    end else begin
      low_q <= low_d;
      wa_q <= wa_d;
    end
  end
  a_reset_quiet: assert property ($fell(rst) |-> !sda_oe && !reg_wr && reg_addr == 8'h00)
    else $error("outputs busy after reset");
  a_wr_one_cycle: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe too long");
  a_drive_scl_low: assert property ($rose(sda_oe) |-> !scl_pin && !$past(scl_pin))
    else $error("SDA driven while SCL high");
  a_addr_advance: assert property (reg_wr |-> ##[1:3] reg_addr == wa_q + 8'h01)
    else $error("address counter not advanced");
  a_bus_timeout: assert property (low_q > TIMEOUT_CYC + 12 |-> !sda_oe)
    else $error("SDA held past timeout");
  a_open_drain: assert property (!sda_out && !ref_in_or_irq_pin_a_out && !wave_or_irq_pin_b_out)
    else $error("open-drain output drives high");
  a_alarm_b_pin: assert property (alarm_two_match && alarm_two_irq_en && irq_steer_select |-> ##2 wave_or_irq_pin_b_oe)
    else $error("alarm two not on pin B");
  a_fast_wave: assert property (!irq_steer_select && wave_rate_sel_hi && wave_rate_sel_lo && $rose(osc_clk_pin)
    |-> ##[2:6] !wave_or_irq_pin_b_oe)
    else $error("fast wave does not follow crystal");
endmodule
bind rtc_status_port rtc_status_port_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_rtc_status_port_checker (.*);

// File: verif/i2c_master_model.sv
// Purpose: Behavioural serial bus master driving SCL and pulling SDA low
// Assumes: SDA resolved with pull-up in the bench
// Notes: Each SCL phase lasts 8 clocks
`timescale 1ns/100ps
module i2c_master_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One SCL phase
  task automatic hp;
    repeat (8) @(posedge clock);
  endtask
  // Start or repeated start
  task automatic start;
    sda_low <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    sda_low <= 1'b1;
    hp;
    scl <= 1'b0;
    hp;
  endtask
  // Stop, SDA rises while SCL high
  task automatic stop;
    sda_low <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    sda_low <= 1'b0;
    hp;
  endtask
  // Nine bit slots, MSB first, wire sampled at each high phase
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= !tx[i];
      hp;
      scl <= 1'b1;
      hp;
      rx[i] = sda;
      scl <= 1'b0;
      hp;
    end
  endtask
endmodule

// File: verif/tb.sv
// Purpose: Self-checking bench for the RTC status block via its serial port
// Assumes: Outside register file answers address xor 5ah
// Notes: Short timeout and reference period
`timescale 1ns/100ps
module tb;
  import rtc_pkg::*;
  logic clock, rst, scl_pin, sda_out, sda_oe, m_low, ref_low, ref_on, reg_wr;
  logic ref_in_or_irq_pin_a_out, ref_in_or_irq_pin_a_oe, wave_or_irq_pin_b_out, wave_or_irq_pin_b_oe;
  logic osc_clk_pin, osc_running_pin, osc_disable_bit, wave_rate_sel_hi, wave_rate_sel_lo, irq_steer_select;
  logic alarm_one_irq_en, alarm_two_irq_en, alarm_one_match, alarm_two_match;
  byte_t reg_addr, reg_wdata, reg_rdata;
  logic [8:0] rx;
  int num_errors = 0;
  int num_checks = 0;
  int rises = 0;
  int n0;
  byte_t wa_seen, wd_seen;
  // Last register write seen on the side port
  always @(posedge clock) begin
    if (reg_wr) begin
      wa_seen <= reg_addr;
      wd_seen <= reg_wdata;
    end
  end
  // Open-drain wires with pull-ups
  wire logic sda_in = !(sda_oe || m_low);
  wire logic ref_in_or_irq_pin_a_in = !(ref_in_or_irq_pin_a_oe || ref_low);
  assign reg_rdata = reg_addr ^ 8'h5a;
  rtc_status_port #(.TIMEOUT_CYC(200), .REF_PER_32K(400)) u_rtc_status_port (.*);
  i2c_master_model u_i2c_master_model (.clock(clock), .sda(sda_in), .scl(scl_pin), .sda_low(m_low));
  // Clock, crystal, reference and wave edge count
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial forever #200 osc_clk_pin = ~osc_clk_pin;
  always #5000 if (ref_on) ref_low = ~ref_low;
  always @(posedge wave_or_irq_pin_b_oe) rises++;
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [8:0] tx, input logic [8:0] e);
    u_i2c_master_model.xfer(tx, rx);
    check(rx, e);
  endtask
  // Write address byte, then register address
  task automatic setp(input byte_t a);
    u_i2c_master_model.start;
    put(9'h1a1, 9'h1a0);
    put({a, 1'b1}, {a, 1'b0});
  endtask
  task automatic wr(input byte_t a, input byte_t d);
    setp(a);
    put({d, 1'b1}, {d, 1'b0});
    u_i2c_master_model.stop;
  endtask
  task automatic rd(input byte_t a, input byte_t e);
    setp(a);
    u_i2c_master_model.start;
    put(9'h1a3, 9'h1a2);
    put(9'h1ff, {e, 1'b1});
    u_i2c_master_model.stop;
  endtask
  task automatic alarm(input logic [1:0] m);
    {alarm_two_match, alarm_one_match} <= m;
    @(posedge clock);
    {alarm_two_match, alarm_one_match} <= 2'b00;
    repeat (4) @(posedge clock);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    final_report;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {osc_clk_pin, osc_disable_bit, wave_rate_sel_hi, wave_rate_sel_lo, irq_steer_select, ref_low, ref_on} = '0;
    {alarm_one_irq_en, alarm_two_irq_en, alarm_one_match, alarm_two_match} = '0;
    osc_running_pin = 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    rd(8'h0f, 8'ha0);
    wr(8'h0f, 8'h00);
    rd(8'h0f, 8'h20);
    wr(8'h0f, 8'hff);
    rd(8'h0f, 8'h7c);
    check(9'(ref_in_or_irq_pin_a_oe), 9'h0);
    ref_on <= 1'b1;
    repeat (1200) @(posedge clock);
    wr(8'h0f, 8'h5c);
    check(9'(wa_seen), 9'h00f);
    check(9'(wd_seen), 9'h05c);
    rd(8'h0f, 8'h5c);
    ref_on <= 1'b0;
    rd(8'h0f, 8'h7c);
    wr(8'h0f, 8'h00);
    osc_disable_bit <= 1'b1;
    repeat (8) @(posedge clock);
    osc_disable_bit <= 1'b0;
    rd(8'h0f, 8'ha0);
    wr(8'h0f, 8'h00);
    alarm_one_irq_en <= 1'b1;
    alarm(2'b11);
    check(9'(ref_in_or_irq_pin_a_oe), 9'h1);
    rd(8'h0f, 8'h23);
    wr(8'h0f, 8'h01);
    rd(8'h0f, 8'h21);
    irq_steer_select <= 1'b1;
    alarm_two_irq_en <= 1'b1;
    alarm(2'b10);
    check(9'(wave_or_irq_pin_b_oe), 9'h1);
    alarm_one_irq_en <= 1'b0;
    repeat (4) @(posedge clock);
    check(9'(ref_in_or_irq_pin_a_oe), 9'h0);
    irq_steer_select <= 1'b0;
    repeat (4) @(posedge clock);
    check(9'(ref_in_or_irq_pin_a_oe), 9'h1);
    for (int r = 0; r < 4; r++) begin
      {wave_rate_sel_hi, wave_rate_sel_lo} <= 2'(r);
      repeat (40) @(posedge clock);
      n0 = rises;
      repeat (1024) @(posedge clock);
      check(9'(rises - n0), 9'(r == 3 ? 64 : r * 8));
    end
    setp(8'h20);
    u_i2c_master_model.start;
    put(9'h1a3, 9'h1a2);
    check(9'(sda_oe), 9'h1);
    repeat (250) @(posedge clock);
    check(9'(sda_oe), 9'h0);
    u_i2c_master_model.stop;
    u_i2c_master_model.start;
    put(9'h141, 9'h141);
    put(9'h01f, 9'h01f);
    u_i2c_master_model.stop;
    setp(8'h03);
    u_i2c_master_model.start;
    put(9'h1a3, 9'h1a2);
    put(9'h1fe, {8'h59, 1'b0});
    put(9'h1ff, {8'h5e, 1'b1});
    u_i2c_master_model.stop;
    final_report;
  end
endmodule
